// >>> core/ewg_guard.sv
`timescale 1ns/1ps
// How it works
// - Write-inhibit high refuses every array write, whatever arrives on the bus.
// - Pulses of 100 ns or shorter on clock or data are ignored.
// - No internal write cycle starts while the supply monitor reports low supply.
// - No array write starts while power-on reset is active.
// - Two lower slave address bits have no pins and are fixed at zero.
// - Software reset received during an internal write cycle is not acted on.
// - Slave address bit 2, just above the two fixed bits, follows the address-select pin.
module ewg_guard
  import ewg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_link_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_wp,
  input wire logic i_addr_sel,
  input wire logic i_supply_low,
  input wire logic i_por,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_array_we,
  output logic o_busy,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready
);
  // =====================================================
  // Shared helpers
  // Lower address bits fixed
  function automatic logic [6:0] slave_addr(input logic hi);
    slave_addr = {DEV_CODE, hi, SLAVE_ADDR_BIT_MID, SLAVE_ADDR_BIT_LOW};
  endfunction : slave_addr

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_COUNT) || (a == REG_ADDR);
  endfunction : reg_hit

  // =====================================================
  // Link domain reset and inputs
  logic [1:0] lrst_sync;
  logic link_rst;
  logic scl_f, sda_f, wp_l, asel_l;
  logic scl_d, sda_d;
  logic [2:0] busy_sync;
  logic busy_l;

  always_ff @(posedge i_link_clk) begin
    lrst_sync <= {lrst_sync[0], i_rst};
  end
  assign link_rst = lrst_sync[1];

  ewg_glitch u_scl_filt (.i_clk(i_link_clk), .i_rst(link_rst), .i_pin(i_scl), .o_level(scl_f));
  ewg_glitch u_sda_filt (.i_clk(i_link_clk), .i_rst(link_rst), .i_pin(i_sda), .o_level(sda_f));
  ewg_glitch u_wp_filt (.i_clk(i_link_clk), .i_rst(link_rst), .i_pin(i_wp), .o_level(wp_l));
  ewg_glitch u_asel_filt (.i_clk(i_link_clk), .i_rst(link_rst), .i_pin(i_addr_sel), .o_level(asel_l));

  always_ff @(posedge i_link_clk) begin
    busy_sync <= {busy_sync[1:0], o_busy};
  end

  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      busy_l <= 1'b0;
    end else if (busy_sync[1] == busy_sync[2]) begin
      busy_l <= busy_sync[2];
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  logic bus_start, bus_stop, scl_rise, scl_fall;
  assign bus_start = scl_f && scl_d && sda_d && !sda_f;
  assign bus_stop = scl_f && scl_d && !sda_d && sda_f;
  assign scl_rise = scl_f && !scl_d;
  assign scl_fall = !scl_f && scl_d;

  // =====================================================
  // Byte framing and selection
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic ack_phase;
  logic [2:0] byte_idx;
  logic selected, in_xfer, wp_seen;
  logic addr_match, byte_end, ack_ok;

  assign addr_match = shreg[7:1] == slave_addr(asel_l);
  assign byte_end = scl_fall && bitcnt == BITS_PER_BYTE && !ack_phase;
  assign ack_ok = !busy_l && ((byte_idx == 3'h0) ? addr_match : selected);

  always_ff @(posedge i_link_clk) begin
    if (link_rst || bus_start || bus_stop) begin
      bitcnt <= '0;
      ack_phase <= 1'b0;
      byte_idx <= '0;
      shreg <= '0;
    end else if (scl_rise && !ack_phase && bitcnt != BITS_PER_BYTE) begin
      shreg <= {shreg[6:0], sda_f};
      bitcnt <= bitcnt + 1'b1;
    end else if (byte_end) begin
      ack_phase <= 1'b1;
      if (byte_idx != 3'h7) begin
        byte_idx <= byte_idx + 1'b1;
      end
    end else if (scl_fall && ack_phase) begin
      ack_phase <= 1'b0;
      bitcnt <= '0;
    end
  end

  // Inhibit level seen anywhere in frame
  always_ff @(posedge i_link_clk) begin
    if (link_rst || bus_stop) begin
      in_xfer <= 1'b0;
      wp_seen <= 1'b0;
      selected <= 1'b0;
    end else if (bus_start) begin
      in_xfer <= 1'b1;
      wp_seen <= wp_l;
      selected <= 1'b0;
    end else begin
      if (in_xfer && wp_l) begin
        wp_seen <= 1'b1;
      end
      if (byte_end && byte_idx == 3'h0) begin
        selected <= addr_match && !shreg[0] && !busy_l;
      end
    end
  end

  // Acknowledge is withheld while busy so the host can poll
  always_ff @(posedge i_link_clk) begin
    if (link_rst || bus_start || bus_stop) begin
      o_sda_oe <= 1'b0;
      o_sda_out <= 1'b0;
    end else if (byte_end) begin
      o_sda_oe <= ack_ok;
    end else if (scl_fall && ack_phase) begin
      o_sda_oe <= 1'b0;
    end
  end

  // =====================================================
  // Write request toward the core domain
  logic wr_tgl, wr_blk;

  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      wr_tgl <= 1'b0;
      wr_blk <= 1'b0;
    end else if (bus_stop && selected && byte_idx >= MIN_WR_BYTES) begin
      wr_blk <= wp_seen || wp_l;
      wr_tgl <= ~wr_tgl;
    end
  end

  // =====================================================
  // Software reset detection
  logic [3:0] swr_cnt;
  logic swr_ok, swr_tgl;

  always_ff @(posedge i_link_clk) begin
    if (link_rst || bus_stop) begin
      swr_cnt <= '0;
      swr_ok <= 1'b0;
    end else if (bus_start) begin
      swr_cnt <= '0;
      swr_ok <= 1'b1;
    end else if (scl_rise) begin
      if (!sda_f) begin
        swr_ok <= 1'b0;
      end else if (swr_cnt != 4'hf) begin
        swr_cnt <= swr_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      swr_tgl <= 1'b0;
    // Ignored during write cycle; the start's own clock rise follows the nine pulses
    end else if (bus_start && swr_ok && swr_cnt == SWR_CLOCKS + 4'h1 && !busy_l) begin
      swr_tgl <= ~swr_tgl;
    end
  end

  chk_swr_not_busy: assert property (@(posedge i_link_clk) disable iff (link_rst)
    $changed(swr_tgl) |-> !$past(busy_l) && $past(swr_cnt) == SWR_CLOCKS + 4'h1)
    else $error("Software reset taken while busy or with wrong clock count");

  chk_addr_low_bits: assert property (@(posedge i_link_clk) disable iff (link_rst)
    byte_end && byte_idx == 3'h0 && ack_ok |=> shreg[2:1] == 2'h0 && shreg[3] == asel_l)
    else $error("Acknowledged an address with wrong select bits");

  chk_ack_withheld: assert property (@(posedge i_link_clk) disable iff (link_rst)
    $rose(o_sda_oe) |-> !$past(busy_l))
    else $error("Acknowledge driven during write cycle");

  // =====================================================
  // Core domain synchronisers
  logic [2:0] wp_s, low_s, por_s, asel_s, wrt_s, swt_s;
  logic wp_c, low_c, por_c, asel_c;
  logic wr_evt, swr_evt;

  always_ff @(posedge i_clk) begin
    wp_s <= {wp_s[1:0], i_wp};
    low_s <= {low_s[1:0], i_supply_low};
    por_s <= {por_s[1:0], i_por};
    asel_s <= {asel_s[1:0], i_addr_sel};
    wrt_s <= {wrt_s[1:0], wr_tgl};
    swt_s <= {swt_s[1:0], swr_tgl};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wp_c <= 1'b1;
      low_c <= 1'b1;
      por_c <= 1'b1;
      asel_c <= 1'b0;
    end else begin
      wp_c <= (wp_s[1] == wp_s[2]) ? wp_s[2] : wp_c;
      low_c <= (low_s[1] == low_s[2]) ? low_s[2] : low_c;
      por_c <= (por_s[1] == por_s[2]) ? por_s[2] : por_c;
      asel_c <= (asel_s[1] == asel_s[2]) ? asel_s[2] : asel_c;
    end
  end

  assign wr_evt = wrt_s[1] ^ wrt_s[2];
  assign swr_evt = swt_s[1] ^ swt_s[2];

  // =====================================================
  // Internal write cycle
  ewg_wr_state_t state;
  logic [15:0] ctrl_len, cyc_cnt, wr_started, wr_refused;
  logic write_ok;

  assign write_ok = !wr_blk && !wp_c && !low_c && !por_c;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= WR_IDLE;
      cyc_cnt <= '0;
      o_array_we <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_array_we <= 1'b0;
      case (state)
        WR_IDLE: begin
          if (wr_evt && write_ok) begin
            state <= WR_BUSY;
            cyc_cnt <= ctrl_len;
            o_array_we <= 1'b1;
            o_busy <= 1'b1;
          end
        end
        WR_BUSY: begin
          if (cyc_cnt <= 16'h0001) begin
            state <= WR_IDLE;
            o_busy <= 1'b0;
          end else begin
            cyc_cnt <= cyc_cnt - 1'b1;
          end
        end
        default: begin
          state <= WR_IDLE;
          o_busy <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_started <= '0;
      wr_refused <= '0;
    end else if (wr_evt) begin
      if (state == WR_IDLE && write_ok) begin
        wr_started <= wr_started + 1'b1;
      end else begin
        wr_refused <= wr_refused + 1'b1;
      end
    end
  end

  chk_wp_blocks_we: assert property (@(posedge i_clk) disable iff (i_rst)
    o_array_we |-> !$past(wp_c) && !$past(wr_blk))
    else $error("Array write started with write-inhibit high");

  chk_low_supply_we: assert property (@(posedge i_clk) disable iff (i_rst)
    o_array_we |-> !$past(low_c))
    else $error("Array write started on low supply");

  chk_por_blocks_we: assert property (@(posedge i_clk) disable iff (i_rst)
    o_array_we |-> !$past(por_c))
    else $error("Array write started during power-on reset");

  chk_busy_follows_we: assert property (@(posedge i_clk) disable iff (i_rst)
    o_array_we |-> o_busy ##1 (o_busy || ctrl_len <= 16'h0001))
    else $error("Busy not raised with the write cycle");

  // =====================================================
  // Register file
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic swr_seen;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_len <= CTRL_RST;
    end else if (wr_en && wr_addr == REG_CTRL) begin
      if (wr_strb[0]) begin
        ctrl_len[7:0] <= wr_data[7:0];
      end
      if (wr_strb[1]) begin
        ctrl_len[15:8] <= wr_data[15:8];
      end
    end
  end

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      swr_seen <= 1'b0;
    end else if (swr_evt) begin
      swr_seen <= 1'b1;
    end else if (wr_en && wr_addr == REG_STATUS && wr_strb[0] && wr_data[ST_SWR]) begin
      swr_seen <= 1'b0;
    end
  end

  always_comb begin
    rd_data = '0;
    case (i_s_axi_araddr)
      REG_CTRL: rd_data[15:0] = ctrl_len;
      REG_STATUS: begin
        rd_data[ST_BUSY] = o_busy;
        rd_data[ST_WP] = wp_c;
        rd_data[ST_LOW] = low_c;
        rd_data[ST_POR] = por_c;
        rd_data[ST_ASEL] = asel_c;
        rd_data[ST_SWR] = swr_seen;
      end
      REG_COUNT: rd_data = {wr_refused, wr_started};
      REG_ADDR: rd_data[6:0] = slave_addr(asel_c);
      default: rd_data = '0;
    endcase
  end

  ewg_axil u_axil (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_awaddr(i_s_axi_awaddr),
    .i_awvalid(i_s_axi_awvalid),
    .o_awready(o_s_axi_awready),
    .i_wdata(i_s_axi_wdata),
    .i_wstrb(i_s_axi_wstrb),
    .i_wvalid(i_s_axi_wvalid),
    .o_wready(o_s_axi_wready),
    .o_bresp(o_s_axi_bresp),
    .o_bvalid(o_s_axi_bvalid),
    .i_bready(i_s_axi_bready),
    .i_arvalid(i_s_axi_arvalid),
    .o_arready(o_s_axi_arready),
    .o_rdata(o_s_axi_rdata),
    .o_rresp(o_s_axi_rresp),
    .o_rvalid(o_s_axi_rvalid),
    .i_rready(i_s_axi_rready),
    .i_rd_data(rd_data),
    .i_rd_hit(reg_hit(i_s_axi_araddr)),
    .i_wr_hit(reg_hit(wr_addr)),
    .o_wr_en(wr_en),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_wr_strb(wr_strb)
  );
endmodule : ewg_guard

// >>> core/ewg_pkg.sv
package ewg_pkg;
  // =====================================================
  // Link timing and glitch filter
  localparam int GLITCH_NS = 100;
  localparam int LINK_PERIOD_PS = 6000;
  // Level must stay stable strictly longer than the noise limit
  localparam int FILT_CYCLES = (GLITCH_NS * 1000) / LINK_PERIOD_PS + 1;
  localparam int FILT_W = 5;
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYCLES - 1);
  // =====================================================
  // Slave address and bus sequences
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam logic SLAVE_ADDR_BIT_MID = 1'b0;
  localparam logic SLAVE_ADDR_BIT_LOW = 1'b0;
  localparam logic [3:0] SWR_CLOCKS = 4'h9;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Slave byte, two address bytes and at least one data byte
  localparam logic [2:0] MIN_WR_BYTES = 3'h4;
  // =====================================================
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_ADDR = 8'h0c;
  localparam logic [15:0] CTRL_RST = 16'h0271;
  localparam int ST_BUSY = 0;
  localparam int ST_WP = 1;
  localparam int ST_LOW = 2;
  localparam int ST_POR = 3;
  localparam int ST_ASEL = 4;
  localparam int ST_SWR = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic {WR_IDLE, WR_BUSY} ewg_wr_state_t;
endpackage : ewg_pkg

// >>> core/ewg_glitch.sv
`timescale 1ns/1ps
module ewg_glitch
  import ewg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_level
);
  logic [2:0] sync;
  logic [FILT_W-1:0] cnt;

  always_ff @(posedge i_clk) begin
    sync <= {sync[1:0], i_pin};
  end

  // =====================================================
  // Stability filter
  // Accept after stable run
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_level <= 1'b1;
      cnt <= '0;
    end else if (sync[1] == sync[2] && sync[2] != o_level) begin
      if (cnt == FILT_LAST) begin
        o_level <= sync[2];
        cnt <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end else begin
      cnt <= '0;
    end
  end

  chk_filter_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !$stable(o_level) |-> $past(cnt) == FILT_LAST)
    else $error("Filtered level changed before the stable run");
endmodule : ewg_glitch

// >>> core/ewg_axil.sv
`timescale 1ns/1ps
module ewg_axil
  import ewg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] i_rd_data,
  input wire logic i_rd_hit,
  input wire logic i_wr_hit,
  output logic o_wr_en,
  output logic [7:0] o_wr_addr,
  output logic [31:0] o_wr_data,
  output logic [3:0] o_wr_strb
);
  logic aw_held;
  logic w_held;

  // =====================================================
  // Write address and data, taken in either order
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      o_awready <= 1'b0;
      o_wr_addr <= '0;
    end else if (i_awvalid && o_awready) begin
      aw_held <= 1'b1;
      o_awready <= 1'b0;
      o_wr_addr <= i_awaddr;
    end else if (o_wr_en) begin
      aw_held <= 1'b0;
      o_awready <= 1'b1;
    end else if (!aw_held) begin
      o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      w_held <= 1'b0;
      o_wready <= 1'b0;
      o_wr_data <= '0;
      o_wr_strb <= '0;
    end else if (i_wvalid && o_wready) begin
      w_held <= 1'b1;
      o_wready <= 1'b0;
      o_wr_data <= i_wdata;
      o_wr_strb <= i_wstrb;
    end else if (o_wr_en) begin
      w_held <= 1'b0;
      o_wready <= 1'b1;
    end else if (!w_held) begin
      o_wready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wr_en <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else begin
      o_wr_en <= aw_held && w_held && !o_bvalid && !o_wr_en;
      if (aw_held && w_held && !o_bvalid && !o_wr_en) begin
        o_bvalid <= 1'b1;
        o_bresp <= i_wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // =====================================================
  // Read channel
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= i_rd_data;
      o_rresp <= i_rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end else if (!o_rvalid) begin
      o_arready <= 1'b1;
    end
  end

  chk_bresp_after_both: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_bvalid) |-> $past(aw_held) && $past(w_held))
    else $error("Write response raised before address and data were both held");
endmodule : ewg_axil

// >>> sim/ewg_host.sv
`timescale 1ns/1ps
// =====================================================
// Bus host model; data released by the host reads high
module ewg_host (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  localparam int HALF = 40;
  // Lines driven high from time zero
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic wt();
    repeat (HALF) @(posedge i_clk);
  endtask : wt
  task automatic start();
    o_sda <= 1'b1;
    wt();
    o_scl <= 1'b1;
    wt();
    o_sda <= 1'b0;
    wt();
    o_scl <= 1'b0;
    wt();
  endtask : start
  task automatic stop();
    o_sda <= 1'b0;
    wt();
    o_scl <= 1'b1;
    wt();
    o_sda <= 1'b1;
    wt();
  endtask : stop
  // Data moves only while the clock is low, never at its edges
  task automatic bit_io(input logic b, output logic r);
    o_sda <= b;
    wt();
    o_scl <= 1'b1;
    wt();
    r = i_sda;
    o_scl <= 1'b0;
    wt();
  endtask : bit_io
  // MSB first, slave bits after the device code
  task automatic send(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, nak);
  endtask : send
  // Start, nine clocks with data released, start
  task automatic swreset();
    logic r;
    start();
    for (int i = 0; i < 9; i++) begin
      bit_io(1'b1, r);
    end
    start();
  endtask : swreset
  // Both lines high first, then the reset sequence
  task automatic recover();
    o_scl <= 1'b1;
    o_sda <= 1'b1;
    wt();
    swreset();
  endtask : recover
  // Clock pulse of 88 ns, under the noise limit
  task automatic glitch();
    o_scl <= 1'b1;
    repeat (11) @(posedge i_clk);
    o_scl <= 1'b0;
    wt();
  endtask : glitch
endmodule : ewg_host

// >>> sim/tb_ewg_guard.sv
`timescale 1ns/1ps
module tb_ewg_guard
  import ewg_pkg::*;
();
  logic i_clk, i_rst, lclk, wp, sel, low, por, scl, hsda, sda, sda_out, sda_oe, we, busy;
  logic awv, wv, arv, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp;
  logic [3:0] nak;
  int error_cnt = 0;
  int total_checks = 0;
  int we_cnt = 0;
  int n;
  // Open-drain data line with pull-up
  assign sda = hsda & !(sda_oe && !sda_out);
  ewg_host host_u (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(hsda));
  ewg_guard dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_link_clk(lclk), .i_scl(scl), .i_sda(sda),
    .i_wp(wp), .i_addr_sel(sel), .i_supply_low(low), .i_por(por), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .o_array_we(we), .o_busy(busy), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(1'b1), .i_s_axi_araddr(araddr),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(1'b1));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    lclk = 1'b0;
    #1.7;
    forever #3 lclk = ~lclk;
  end
  always @(posedge i_clk) begin
    if (we === 1'b1) we_cnt <= we_cnt + 1;
  end
  // =====================================================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  // Responses are always accepted, so bready and rready stay high
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge i_clk);
      if (awready === 1'b1) awv <= 1'b0;
      if (wready === 1'b1) wv <= 1'b0;
    end while (bvalid !== 1'b1);
    chk(bresp, er);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    araddr <= a;
    arv <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arready === 1'b1) arv <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    chk(rresp, er);
  endtask : axr
  task automatic xfer(input logic [7:0] sa, input logic g);
    host_u.start();
    host_u.send(sa, nak[3]);
    if (g) host_u.glitch();
    host_u.send(8'h00, nak[2]);
    host_u.send(8'h10, nak[1]);
    host_u.send(8'h5a, nak[0]);
    host_u.stop();
    repeat (20) @(posedge i_clk);
  endtask : xfer
  task automatic wait_idle();
    while (busy !== 1'b0) @(posedge i_clk);
  endtask : wait_idle
  // =====================================================
  // Scenarios
  task automatic t_regs();
    axr(REG_CTRL, RESP_OKAY, d);
    chk(d, 32'h0000_0271);
    axr(REG_ADDR, RESP_OKAY, d);
    chk(d, 32'h0000_0050);
    axr(8'h10, RESP_DECERR, d);
    axw(8'h14, 32'h0, RESP_DECERR);
    axw(REG_CTRL, 32'h0000_1000, RESP_OKAY);
    axr(REG_CTRL, RESP_OKAY, d);
    chk(d, 32'h0000_1000);
  endtask : t_regs
  task automatic t_swr();
    host_u.recover();
    host_u.stop();
    axr(REG_STATUS, RESP_OKAY, d);
    chk(d[ST_SWR], 1'b1);
    axw(REG_STATUS, 32'h1 << ST_SWR, RESP_OKAY);
    axr(REG_STATUS, RESP_OKAY, d);
    chk(d[ST_SWR], 1'b0);
  endtask : t_swr
  // A good write, with an optional clock glitch, checked while the cycle still runs
  task automatic t_write(input logic g);
    n = we_cnt;
    xfer({DEV_CODE, 3'b000, 1'b0}, g);
    chk(nak, 4'h0);
    chk(we_cnt - n, 1);
    chk(busy, 1'b1);
  endtask : t_write
  task automatic t_busy_swr();
    host_u.swreset();
    host_u.stop();
    axr(REG_STATUS, RESP_OKAY, d);
    chk(d[ST_SWR], 1'b0);
    chk(d[ST_BUSY], 1'b1);
    // Address poll during the write cycle gets no acknowledge
    host_u.start();
    host_u.send({DEV_CODE, 3'b000, 1'b0}, nak[3]);
    host_u.stop();
    chk(nak[3], 1'b1);
    wait_idle();
  endtask : t_busy_swr
  // Each inhibit source held from before start to after stop
  task automatic t_inhibit();
    for (int k = 0; k < 3; k++) begin
      {wp, low, por} <= 3'b100 >> k;
      repeat (10) @(posedge i_clk);
      n = we_cnt;
      xfer({DEV_CODE, 3'b000, 1'b0}, 1'b0);
      chk(we_cnt - n, 0);
      {wp, low, por} <= 3'b000;
      repeat (10) @(posedge i_clk);
    end
    axr(REG_COUNT, RESP_OKAY, d);
    chk(d, 32'h0003_0001);
  endtask : t_inhibit
  task automatic t_sel();
    sel <= 1'b1;
    repeat (10) @(posedge i_clk);
    axr(REG_ADDR, RESP_OKAY, d);
    chk(d, 32'h0000_0054);
    xfer(8'ha0, 1'b0);
    chk(nak[3], 1'b1);
    // Read direction: address acknowledged, nothing selected for writing
    n = we_cnt;
    xfer(8'ha9, 1'b0);
    chk(nak, 4'h7);
    chk(we_cnt - n, 0);
    n = we_cnt;
    xfer(8'ha8, 1'b0);
    chk(nak, 4'h0);
    chk(we_cnt - n, 1);
  endtask : t_sel
  initial begin
    i_rst = 1'b1;
    {wp, sel, low, por} = 4'b0001;
    {awv, wv, arv} = 3'b000;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (10) @(posedge i_clk);
    t_regs();
    por <= 1'b0;
    repeat (10) @(posedge i_clk);
    t_swr();
    t_write(1'b0);
    t_busy_swr();
    t_inhibit();
    t_write(1'b1);
    wait_idle();
    t_sel();
    test_done();
  end
  initial begin
    repeat (90000) @(posedge i_clk);
    error_cnt++;
    test_done();
  end
endmodule : tb_ewg_guard
